//--- design/sslp_serial_core.sv
// serial programming, reset sequencing and fast-settle control
// Operation
// - 21-bit word: 19 payload, 2 select last
// - select 00 ref, 10 fb, 01 fn, 11 init
// - init writes function latch plus reset pulse
// - pulse reloads counters, tristates the pump
// - pulse with enable, bits 2,18 powers down
// - first feedback load after init pulses again
// - loads accepted in powerdown; aligned restart
// - latches survive chip enable cycling
// - counter reset bit holds counters, tristates
// - clearing it restarts counters in alignment
// - feedback: trigger, 13 coarse, 5 swallow
// - reference: precision, test bits, divide ratio
// - msb first, select bits last
// - mode 100: boost until trigger cleared
// - mode 101: boost for timeout, self-clear
// - quarter modes use same fields, trigger
// - timeout 3 plus weighted bits, per cycle
// - quarter modes divide ratios by four
// - trigger forces high gain until cleared
// - data captured on serial clock rise
`timescale 1ns/1ps
`default_nettype none
module sslp_serial_core import sslp_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // serial pins and chip enable
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_le,
  input wire logic chip_enable,
  // divided feedback input from the prescaler
  input wire logic fb_in,
  // pump and status
  output logic pump_tristate_r,
  output logic pump_current_output_r,
  output logic quarter_div_r,
  output logic powerdown_r,
  output logic lock_detect_precision_r,
  // fast-settle pin, open drain
  output logic fast_settle_output_pin_o_r,
  output logic fast_settle_output_pin_oe_n_r,
  // comparison ticks
  output logic ref_tick_r,
  output logic fb_tick_r
);
  // sync chain resets to the pins' idle levels; enable idles high
  localparam logic [LN_W-1:0] SYNC_IDLE = {{(LN_W-1){1'b0}}, 1'b1} << LN_LE;
  logic [LN_W-1:0] sync1_r;
  logic [LN_W-1:0] sync2_r;
  logic [LN_W-1:0] sync3_r;
  logic sclk_rise;
  logic le_rise;
  logic [WORD_W-1:0] sr_r;
  logic [PAY_W-1:0] payload;
  sslp_target_t tgt;
  logic we_ref;
  logic we_fb;
  logic we_fn;
  logic is_init;
  logic go_clr;
  logic [PAY_W-1:0] ref_lat;
  logic [PAY_W-1:0] fb_lat;
  logic [PAY_W-1:0] fn_lat;
  logic init_armed_r;
  logic rst_pulse_r;
  logic sync_pd_r;
  logic hold;
  logic fs_active;
  logic timed;
  logic [RDIV_W-1:0] ref_cnt_r;
  logic [RDIV_W-1:0] ref_ratio;
  logic [NDIV_W-1:0] fb_cnt_r;
  logic [NDIV_W-1:0] fb_ratio;
  logic [TO_W-1:0] to_cnt_r;
  logic [TO_W-1:0] to_len;

  ////////////////////////////////////////////////////////////////
  // pins come from outside: two flops, third stage only for edges
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= SYNC_IDLE;
      sync2_r <= SYNC_IDLE;
      sync3_r <= SYNC_IDLE; // a zero here would fake a load edge after reset
    end else if (clk_en) begin
      sync1_r <= {fb_in, chip_enable, ser_le, ser_data, ser_clk};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  assign sclk_rise = sync2_r[LN_SCLK] & ~sync3_r[LN_SCLK];
  assign le_rise = sync2_r[LN_LE] & ~sync3_r[LN_LE];

  ////////////////////////////////////////////////////////////////
  // shift register: newest bit at bit 0, so select bits end lowest
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sr_r <= '0;
    end else if (clk_en && sclk_rise && !sync2_r[LN_LE]) begin
      sr_r <= {sr_r[WORD_W-2:0], sync2_r[LN_SDAT]};
    end
  end

  // word split and target decode
  assign payload = sr_r[PAY_MSB:PAY_LSB];
  assign tgt = sslp_decode(sr_r[SEL_C1], sr_r[SEL_C2]);
  assign is_init = le_rise && (tgt == TGT_INIT);
  assign we_ref = le_rise && (tgt == TGT_REF);
  assign we_fb = le_rise && (tgt == TGT_FB);
  assign we_fn = le_rise && ((tgt == TGT_FN) || (tgt == TGT_INIT));

  ////////////////////////////////////////////////////////////////
  // latch storage, reset only at power-on
  sslp_latch_bank u_bank (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .we_ref(we_ref),
    .we_fb(we_fb),
    .we_fn(we_fn),
    .go_clr(go_clr),
    .wdata(payload),
    .ref_q(ref_lat),
    .fb_q(fb_lat),
    .fn_q(fn_lat)
  );

  ////////////////////////////////////////////////////////////////
  // internal reset pulse: on init, and on the first feedback load after it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      init_armed_r <= 1'b0;
      rst_pulse_r <= 1'b0;
    end else if (clk_en) begin
      rst_pulse_r <= is_init || (we_fb && init_armed_r);
      if (is_init) init_armed_r <= 1'b1;
      else if (we_fb) init_armed_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // synchronous powerdown, armed only by the reset pulse
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync_pd_r <= 1'b0;
    end else if (clk_en) begin
      if (rst_pulse_r && sync2_r[LN_CE] && fn_lat[FB_PD_A] && fn_lat[FB_PD_B]) begin
        sync_pd_r <= 1'b1;
      end else if (!fn_lat[FB_PD_A] || !fn_lat[FB_PD_B]) begin
        sync_pd_r <= 1'b0;
      end
    end
  end

  // chip enable low powers down; latches keep loading meanwhile
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      powerdown_r <= 1'b1;
    end else if (clk_en) begin
      powerdown_r <= !sync2_r[LN_CE] || sync_pd_r;
    end
  end

  ////////////////////////////////////////////////////////////////
  // effective divide ratios; quarter mode shortens both together
  assign fs_active = fn_lat[FB_FS_EN] && fb_lat[NB_GO];
  assign timed = fn_lat[FB_FS_TMR];
  always_comb begin
    ref_ratio = ref_lat[RB_DIV_MSB:RB_DIV_LSB];
    fb_ratio = NDIV_W'({fb_lat[NB_B_MSB:NB_B_LSB], {PRESC_SHIFT{1'b0}}})
      + NDIV_W'(fb_lat[NB_A_MSB:NB_A_LSB]);
    if (fs_active && fn_lat[FB_FS_QTR]) begin
      ref_ratio = ref_ratio >> QTR_SHIFT;
      fb_ratio = fb_ratio >> QTR_SHIFT;
    end
  end
  // both counters reload together, so they leave the hold aligned
  assign hold = rst_pulse_r || fn_lat[FB_CNT_RST] || powerdown_r;

  ////////////////////////////////////////////////////////////////
  // reference counter runs on the oscillator, here ref_clk
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ref_cnt_r <= RDIV_ONE;
      ref_tick_r <= 1'b0;
    end else if (clk_en) begin
      ref_tick_r <= 1'b0;
      if (hold) begin
        ref_cnt_r <= ref_ratio;
      end else if (ref_cnt_r <= RDIV_ONE) begin
        ref_cnt_r <= ref_ratio;
        ref_tick_r <= 1'b1;
      end else begin
        ref_cnt_r <= ref_cnt_r - RDIV_ONE;
      end
    end
  end

  // feedback counter steps on each feedback input rise
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fb_cnt_r <= NDIV_ONE;
      fb_tick_r <= 1'b0;
    end else if (clk_en) begin
      fb_tick_r <= 1'b0;
      if (hold) begin
        fb_cnt_r <= fb_ratio;
      end else if (sync2_r[LN_FB] && !sync3_r[LN_FB]) begin
        if (fb_cnt_r <= NDIV_ONE) begin
          fb_cnt_r <= fb_ratio;
          fb_tick_r <= 1'b1;
        end else begin
          fb_cnt_r <= fb_cnt_r - NDIV_ONE;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // timeout: 3 plus 4x the field, one step per comparison cycle
  assign to_len = TO_BASE + {fn_lat[FB_TO_MSB:FB_TO_LSB], 2'h0};
  assign go_clr = clk_en && fs_active && timed && ref_tick_r && (to_cnt_r <= TO_ONE);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      to_cnt_r <= TO_BASE;
    end else if (clk_en) begin
      if (rst_pulse_r) begin
        to_cnt_r <= to_len;
      end else if (we_fb && payload[NB_GO] && timed) begin
        to_cnt_r <= to_len;
      end else if (fs_active && timed && ref_tick_r && to_cnt_r > TO_ONE) begin
        to_cnt_r <= to_cnt_r - TO_ONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // pump and pin state; untimed modes wait for the host to clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pump_tristate_r <= 1'b1;
      pump_current_output_r <= 1'b0;
      quarter_div_r <= 1'b0;
      lock_detect_precision_r <= 1'b0;
      fast_settle_output_pin_o_r <= 1'b0;
      fast_settle_output_pin_oe_n_r <= 1'b1;
    end else if (clk_en) begin
      pump_tristate_r <= hold;
      pump_current_output_r <= fs_active;
      quarter_div_r <= fs_active && fn_lat[FB_FS_QTR];
      lock_detect_precision_r <= ref_lat[RB_LDP];
      fast_settle_output_pin_o_r <= 1'b0;
      fast_settle_output_pin_oe_n_r <= !fs_active;
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  a_shift_msb: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (sclk_rise && !sync2_r[LN_LE]) |=> (sr_r[0] == $past(sync2_r[LN_SDAT])))
    else $error("serial bit not shifted in at bit 0");
  a_fn_route: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (le_rise && (tgt == TGT_FN || tgt == TGT_INIT)) |=> (fn_lat == $past(payload)))
    else $error("function latch not loaded");
  a_ref_route: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (le_rise && sr_r[SEL_C1:SEL_C2] == 2'h0) |=> (ref_lat == $past(payload)) && $stable(fn_lat))
    else $error("reference word misrouted");
  a_init_pulse: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    is_init |=> rst_pulse_r ##1 (pump_tristate_r && !rst_pulse_r))
    else $error("init load gave no single reset pulse");
  a_fb_repeat: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (we_fb && !init_armed_r) |=> !rst_pulse_r)
    else $error("repeat feedback load pulsed reset");
  a_fb_first: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (we_fb && init_armed_r) |=> (rst_pulse_r && !init_armed_r))
    else $error("first feedback load after init missed pulse");
  a_sync_pd: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (rst_pulse_r && sync2_r[LN_CE] && fn_lat[FB_PD_A] && fn_lat[FB_PD_B]) |=> ##1 powerdown_r)
    else $error("synchronous powerdown not entered");
  a_cnt_hold: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (fn_lat[FB_CNT_RST] && !rst_pulse_r) |=> (ref_cnt_r == $past(ref_ratio)) && !ref_tick_r)
    else $error("counter reset did not hold reference counter");
  a_retain_ce: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    ($changed(sync2_r[LN_CE]) && !le_rise) |=> $stable(fn_lat) && $stable(ref_lat))
    else $error("latch changed on chip enable edge");
  a_to_load: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (we_fb && payload[NB_GO] && timed && !rst_pulse_r) |=> (to_cnt_r == $past(to_len)))
    else $error("timeout not loaded from function field");
  a_go_clear: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (go_clr && !we_fb) |=> !fb_lat[NB_GO] ##1 !pump_current_output_r)
    else $error("timeout did not end boost");
  a_quarter: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (fs_active && fn_lat[FB_FS_QTR]) |=> quarter_div_r && pump_current_output_r)
    else $error("quarter mode not applied");
  // routing and shifting
  a_fb_route: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (le_rise && tgt == TGT_FB) |=> (fb_lat == $past(payload)) && $stable(fn_lat) && $stable(ref_lat))
    else $error("feedback word misrouted");
  a_sr_hold: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    sync2_r[LN_LE] |=> $stable(sr_r))
    else $error("shift register moved while enable high");
  // reset pulse, hold and powerdown
  a_pulse_reload: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    rst_pulse_r |=> (ref_cnt_r == $past(ref_ratio)) && (fb_cnt_r == $past(fb_ratio))
      && (to_cnt_r == $past(to_len)) && pump_tristate_r)
    else $error("reset pulse did not reload counters");
  a_pd_enter: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    !sync2_r[LN_CE] |=> powerdown_r)
    else $error("chip enable low did not power down");
  a_pd_hold: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    powerdown_r |=> !ref_tick_r && !fb_tick_r)
    else $error("counters ticked in powerdown");
  a_fb_hold: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    fn_lat[FB_CNT_RST] |=> (fb_cnt_r == $past(fb_ratio)) && !fb_tick_r)
    else $error("counter reset did not hold feedback counter");
  a_cnt_no_pd: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (fn_lat[FB_CNT_RST] && !sync_pd_r && sync2_r[LN_CE]) |=> !powerdown_r)
    else $error("counter reset entered powerdown");
  a_restart: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (!hold && $past(hold)) |-> (ref_cnt_r == $past(ref_ratio)) && (fb_cnt_r == $past(fb_ratio)))
    else $error("counters left hold out of alignment");
  // fast settle
  a_boost_set: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (we_fb && payload[NB_GO] && fn_lat[FB_FS_EN]) |=> fs_active)
    else $error("trigger did not force high gain");
  a_boost_hold: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (fs_active && !timed && !we_fb) |=> fb_lat[NB_GO])
    else $error("untimed boost ended without host write");
  a_to_count: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (fs_active && timed && ref_tick_r && (to_cnt_r > TO_ONE) && !rst_pulse_r && !we_fb)
      |=> (to_cnt_r == $past(to_cnt_r) - TO_ONE))
    else $error("timeout did not step on comparison cycle");
  a_pin_drive: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    fs_active |=> !fast_settle_output_pin_oe_n_r && !fast_settle_output_pin_o_r)
    else $error("fast settle pin not driven low");
endmodule : sslp_serial_core
`default_nettype wire

//--- design/sslp_pkg.sv
// package: constants, latch field layout and target decoding for the serial latch block
package sslp_pkg;
  // serial word geometry
  localparam int WORD_W = 21;
  localparam int PAY_W = 19;
  localparam int SEL_C1 = 1;
  localparam int SEL_C2 = 0;
  localparam int PAY_LSB = 2;
  localparam int PAY_MSB = 20;
  // function latch fields, payload index = field bit - 1
  localparam int FB_CNT_RST = 0;
  localparam int FB_PD_A = 1;
  localparam int FB_PD_B = 17;
  localparam int FB_FS_EN = 7;
  localparam int FB_FS_QTR = 8;
  localparam int FB_FS_TMR = 9;
  localparam int FB_TO_LSB = 10;
  localparam int FB_TO_MSB = 13;
  // feedback latch fields
  localparam int NB_GO = 18;
  localparam int NB_B_MSB = 17;
  localparam int NB_B_LSB = 5;
  localparam int NB_A_MSB = 4;
  localparam int NB_A_LSB = 0;
  // reference latch fields
  localparam int RB_LDP = 18;
  localparam int RB_DIV_MSB = 13;
  localparam int RB_DIV_LSB = 0;
  // counter widths and constants
  localparam int RDIV_W = 14;
  localparam int NDIV_W = 18;
  localparam int TO_W = 6;
  localparam int PRESC_SHIFT = 5;
  localparam int QTR_SHIFT = 2;
  localparam logic [TO_W-1:0] TO_BASE = 6'h03;
  localparam logic [PAY_W-1:0] LATCH_RST = 19'h00000;
  localparam logic [RDIV_W-1:0] RDIV_ONE = 14'h0001;
  localparam logic [NDIV_W-1:0] NDIV_ONE = 18'h00001;
  localparam logic [TO_W-1:0] TO_ONE = 6'h01;
  // synchroniser input lanes
  localparam int LN_SCLK = 0;
  localparam int LN_SDAT = 1;
  localparam int LN_LE = 2;
  localparam int LN_CE = 3;
  localparam int LN_FB = 4;
  localparam int LN_W = 5;

  typedef enum logic [1:0] {TGT_REF, TGT_FB, TGT_FN, TGT_INIT} sslp_target_t;

  // target select pair, first bit then second bit
  function automatic sslp_target_t sslp_decode(input logic c1, input logic c2);
    unique case ({c1, c2})
      2'h0: sslp_decode = TGT_REF;
      2'h2: sslp_decode = TGT_FB;
      2'h1: sslp_decode = TGT_FN;
      2'h3: sslp_decode = TGT_INIT;
    endcase
  endfunction : sslp_decode
endpackage : sslp_pkg

//--- design/sslp_latch_bank.sv
// three programming latches with registered read data
`timescale 1ns/1ps
`default_nettype none
module sslp_latch_bank import sslp_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // write side
  input wire logic we_ref,
  input wire logic we_fb,
  input wire logic we_fn,
  input wire logic go_clr,
  input wire logic [PAY_W-1:0] wdata,
  // read side
  output logic [PAY_W-1:0] ref_q,
  output logic [PAY_W-1:0] fb_q,
  output logic [PAY_W-1:0] fn_q
);
  ////////////////////////////////////////////////////////////////
  // only power-on reset clears them, bar the timeout self-clear of the feedback trigger bit; chip enable never touches them
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ref_q <= LATCH_RST;
      fb_q <= LATCH_RST;
      fn_q <= LATCH_RST;
    end else if (clk_en) begin
      if (we_ref) ref_q <= wdata;
      if (we_fn) fn_q <= wdata;
      // a fresh host word wins over the timeout self-clear
      if (we_fb) fb_q <= wdata;
      else if (go_clr) fb_q[NB_GO] <= 1'b0;
    end
  end
endmodule : sslp_latch_bank
`default_nettype wire

//--- verif/sslp_host.sv
// host model: drives the three-wire programming link of the serial core
`timescale 1ns/1ps
`default_nettype none
module sslp_host import sslp_pkg::*; (
  // clock the host paces itself on
  input wire logic ref_clk,
  // serial link
  output logic ser_clk,
  output logic ser_data,
  output logic ser_le
);
  // link idles with the enable high and the serial clock still
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_le = 1'b1;
  end

  // one word, msb first, select bits last; each level held 4 cycles (160 ns)
  task automatic send(input logic [WORD_W-1:0] w);
    @(posedge ref_clk);
    ser_le <= 1'b0;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      ser_data <= w[i];
      repeat (4) @(posedge ref_clk);
      ser_clk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      ser_clk <= 1'b0;
    end
    // released data shows the inverse so a stale level is never trusted
    ser_le <= 1'b1;
    ser_data <= ~w[0];
  endtask : send
endmodule : sslp_host
`default_nettype wire

//--- verif/synth_serial_latch_programming_test.sv
// self-checking bench for the serial latch programming core
`timescale 1ns/1ps
`default_nettype none
module synth_serial_latch_programming_test import sslp_pkg::*;;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic chip_enable = 1'b1;
  logic fb_in = 1'b0;
  logic ser_clk, ser_data, ser_le;
  logic tri_r, cur_r, qtr_r, pd_r, ldp_r, fs_o, fs_oe_n, rtick, ftick;
  logic ts_seen;
  logic [PAY_W-1:0] f;
  int fail_count = 0;
  int n_compared = 0;
  int c;
  logic hi;
  logic pt;
  int cf;
  logic clk_en = 1'b1;

  always #20 ref_clk = ~ref_clk;
  // slow feedback edges so the synchroniser never misses one
  always begin
    repeat (3) @(posedge ref_clk);
    fb_in <= ~fb_in;
  end

  sslp_host sslp_host_inst (.ref_clk(ref_clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_le(ser_le));

  sslp_serial_core sslp_serial_core_inst (
    .ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_le(ser_le), .chip_enable(chip_enable), .fb_in(fb_in), .pump_tristate_r(tri_r),
    .pump_current_output_r(cur_r), .quarter_div_r(qtr_r), .powerdown_r(pd_r),
    .lock_detect_precision_r(ldp_r), .fast_settle_output_pin_o_r(fs_o),
    .fast_settle_output_pin_oe_n_r(fs_oe_n), .ref_tick_r(rtick), .fb_tick_r(ftick));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : check

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  // send a word and note any high-impedance pulse in the following cycles
  task automatic load(input logic [WORD_W-1:0] w);
    sslp_host_inst.send(w);
    ts_seen = 1'b0;
    repeat (10) begin
      @(posedge ref_clk);
      #1;
      if (tri_r === 1'b1) ts_seen = 1'b1;
    end
  endtask : load

  task automatic count_ticks(input int n);
    c = 0;
    cf = 0;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      if (rtick === 1'b1) c++;
      if (ftick === 1'b1) cf++;
    end
  endtask : count_ticks

  // word builders; test bits zero, coarse 3 not below swallow 1
  function automatic logic [WORD_W-1:0] ref_w(input logic ldp);
    return {ldp, 4'h0, 14'h0010, 2'h0};
  endfunction : ref_w

  function automatic logic [WORD_W-1:0] fb_w(input logic go);
    return {go, 13'h0003, 5'h01, 2'h2};
  endfunction : fb_w

  function automatic logic [WORD_W-1:0] fn_w(input logic [PAY_W-1:0] fv, input logic init);
    return {fv, init, 1'b1};
  endfunction : fn_w

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    check("powerdown in reset", 1'b1, pd_r);
    check("tristate in reset", 1'b1, tri_r);
    check("current in reset", 1'b0, cur_r);
    check("oe_n in reset", 1'b1, fs_oe_n);
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge ref_clk);

    // initialization sequence
    load(fn_w(19'h00000, 1'b1));
    check("init pulse", 1'b1, ts_seen);
    load(ref_w(1'b1));
    check("precision bit", 1'b1, ldp_r);
    load(fb_w(1'b0));
    check("first fb pulse", 1'b1, ts_seen);
    load(fb_w(1'b0));
    check("second fb pulse", 1'b0, ts_seen);
    check("fast pin driven value", 1'b0, fs_o);
    $display("test init sequence done");

    // counter reset bit
    f = 19'h00000;
    f[FB_CNT_RST] = 1'b1;
    load(fn_w(f, 1'b0));
    check("hold tristate", 1'b1, tri_r);
    check("hold no powerdown", 1'b0, pd_r);
    count_ticks(40);
    check("ticks held", 1'b1, c == 0);
    check("fb ticks held", 1'b1, cf == 0);
    load(fn_w(19'h00000, 1'b0));
    check("release tristate", 1'b0, tri_r);
    // feedback ratio 97 at one rise per 6 cycles needs about 600 cycles
    count_ticks(700);
    check("ticks resume", 1'b1, c > 0);
    check("fb ticks resume", 1'b1, cf > 0);
    $display("test counter reset done");

    // fast-settle modes: bit1 quarter, bit0 timed, bit2 longer timeout
    for (int m = 0; m < 5; m++) begin
      f = 19'h00000;
      f[FB_FS_EN] = 1'b1;
      f[FB_FS_QTR] = m[1];
      f[FB_FS_TMR] = m[0] | m[2];
      f[FB_TO_LSB] = m[2];
      load(fn_w(f, 1'b0));
      sslp_host_inst.send(fb_w(1'b1));
      if (m[0] | m[2]) begin
        c = 0;
        hi = 1'b0;
        pt = 1'b0;
        for (int k = 0; k < 600; k++) begin
          @(posedge ref_clk);
          #1;
          // a tick is spent by the boost that the pump shows one cycle later
          if (cur_r === 1'b1) begin
            hi = 1'b1;
            if (pt === 1'b1) c++;
          end else if (hi) break;
          pt = rtick;
        end
        if (cur_r === 1'b1 || !hi) begin
          $display("[FAIL] boost window expected %b seen %b", 1'b0, cur_r);
          fail_count++;
          end_of_test();
        end
        check("boost rose", 1'b1, hi);
        check("boost ended", 1'b0, cur_r);
        check("timeout length", 1'b1, c == 3 + 4 * m[2]);
      end else begin
        repeat (40) @(posedge ref_clk);
        #1;
        check("boost held", 1'b1, cur_r);
        check("fast pin enabled", 1'b0, fs_oe_n);
        check("quarter", m[1], qtr_r);
        load(fb_w(1'b0));
      end
      check("boost off", 1'b0, cur_r);
      check("fast pin released", 1'b1, fs_oe_n);
      check("quarter off", 1'b0, qtr_r);
    end
    $display("test fast settle done");

    // synchronous and pin powerdown
    f = 19'h00000;
    f[FB_PD_A] = 1'b1;
    f[FB_PD_B] = 1'b1;
    load(fn_w(f, 1'b1));
    check("sync powerdown", 1'b1, pd_r);
    load(fn_w(19'h00000, 1'b0));
    check("sync powerdown off", 1'b0, pd_r);
    @(posedge ref_clk);
    chip_enable <= 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    check("pin powerdown", 1'b1, pd_r);
    load(ref_w(1'b0));
    check("load in powerdown", 1'b0, ldp_r);
    @(posedge ref_clk);
    chip_enable <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    check("enabled again", 1'b0, pd_r);
    check("latch retained", 1'b0, ldp_r);
    count_ticks(40);
    check("ticks after enable", 1'b1, c > 0);
    // frozen clock enable: a word sent meanwhile never reaches a latch
    @(posedge ref_clk);
    clk_en <= 1'b0;
    sslp_host_inst.send(ref_w(1'b1));
    repeat (10) @(posedge ref_clk);
    clk_en <= 1'b1;
    repeat (10) @(posedge ref_clk);
    #1;
    check("frozen load ignored", 1'b0, ldp_r);
    $display("test powerdown done");
    end_of_test();
  end
endmodule : synth_serial_latch_programming_test
`default_nettype wire
